// file: inc/ram_block_pkg.sv
// Shared constants, types and register layout of the embedded RAM block
`default_nettype none
package ram_block_pkg;
   // Storage geometry
   localparam int          ADDR_W     = 11;        // Word address width at 2048 x 1
   localparam int          DATA_W     = 8;         // Widest word
   localparam int          ROWS       = 256;       // Physical rows of eight bits
   localparam int          TOTAL_BITS = 2048;      // Bits held in one block
   localparam int          GLB_N      = 4;         // Device-wide global signals
   localparam int          BANK_W     = 3;         // Bank number width for depth cascading
   localparam int          CNT_W      = 12;        // FIFO fill count width
   localparam logic [11:0] DEPTH_BASE = 12'h100;   // Word count at 256 x 8
   localparam logic [7:0]  FILL_LAST  = 8'hff;     // Last entry of the product table

   // Register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_CLKSEL = 12'h004;
   localparam logic [11:0] OFS_LDADDR = 12'h008;
   localparam logic [11:0] OFS_LDDATA = 12'h00c;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam int          FILL_BIT   = 16;        // Write one in CTRL starts the table fill

   // Operating modes, word organisations and clock sources
   typedef enum logic [1:0] {MODE_RAM, MODE_ROM, MODE_DPRAM, MODE_FIFO} mode_e;
   typedef enum logic [1:0] {ORG_256X8, ORG_512X4, ORG_1KX2, ORG_2KX1} org_e;
   typedef enum logic [1:0] {SRC_GLOBAL, SRC_PIN, SRC_LOCAL} csrc_e;
   typedef enum logic       {FILL_IDLE, FILL_RUN} fill_e;

   // Control register, bits [10:0]
   typedef struct packed {
      logic [BANK_W-1:0] bank_id;   // Bank answered when cascaded
      logic              casc_en;   // Depth cascading on
      logic              reg_addr;  // Address and write request stage used
      logic              reg_dout;  // Output stage used
      logic              reg_din;   // Write data stage used
      org_e              org;       // Word organisation
      mode_e             mode;      // Operating mode
   } ctrl_s;

   // Clock and strobe source register, bits [14:0]
   typedef struct packed {
      logic [GLB_N-1:0] glb_from_logic; // Per global: 1 internal logic, 0 dedicated pin
      logic [1:0]       we_glb;         // Global used for the write request
      logic [1:0]       out_glb;        // Global used for the output clock
      logic [1:0]       in_glb;         // Global used for the input clock
      logic             we_from_glb;    // Write request from a global, else local
      csrc_e            out_src;        // Output clock source
      csrc_e            in_src;         // Input clock source
   } clksel_s;

   // Status register, bits [15:0]
   typedef struct packed {
      logic             hit;        // Block selected by the bank address
      logic             fill_busy;  // Product table fill running
      logic             full;       // FIFO full
      logic             empty;      // FIFO empty
      logic [CNT_W-1:0] count;      // FIFO words held
   } status_s;

   localparam ctrl_s   CTRL_RST   = '{bank_id: '0, casc_en: 1'b0, reg_addr: 1'b0,
                                      reg_dout: 1'b0, reg_din: 1'b0, org: ORG_256X8,
                                      mode: MODE_RAM};
   localparam clksel_s CLKSEL_RST = '{glb_from_logic: '0, we_glb: 2'h0, out_glb: 2'h0,
                                      in_glb: 2'h0, we_from_glb: 1'b0, out_src: SRC_LOCAL,
                                      in_src: SRC_LOCAL};
endpackage : ram_block_pkg
`default_nettype wire

// file: rtl/ram_array.sv
// Flip-flop storage of 2048 bits with a word organisation chosen at run time
`default_nettype none
module ram_array
   import ram_block_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              ce_i,
   input  wire logic              we_i,
   input  wire org_e              org_i,
   input  wire logic [ADDR_W-1:0] waddr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic [ADDR_W-1:0] raddr_i,
   output logic      [DATA_W-1:0] rdata_o
);
   logic [DATA_W-1:0] mem [ROWS];         // Eight-bit rows
   logic [2:0]        shift;              // Row index shift for the organisation
   logic [7:0]        wrow;               // Row hit by the write
   logic [7:0]        rrow;               // Row hit by the read
   logic [2:0]        rlane;              // First bit of the read word in its row
   logic [DATA_W-1:0] mask;               // Bits written in the row
   logic [DATA_W-1:0] wbits;              // Write data spread across the lanes
   logic [DATA_W-1:0] rword;              // Read row shifted down to the word

   // Row and lane from the word address
   assign shift = {1'b0, org_i};
   assign wrow  = 8'(waddr_i >> shift);
   assign rrow  = 8'(raddr_i >> shift);
   assign rlane = 3'(raddr_i[2:0] << (2'd3 - org_i));
   assign rword = mem[rrow] >> rlane;

   // Read word masked to the organisation width
   assign rdata_o = rword & (8'hff >> (4'd8 - (4'd8 >> org_i)));

   // Per-bit write mask and data lane
   for (genvar b = 0; b < DATA_W; b++) begin : g_lane
      localparam logic [2:0] B = 3'(b);
      assign mask[b]  = (org_i == ORG_256X8) ||
                        (org_i == ORG_512X4 && waddr_i[0] == B[2]) ||
                        (org_i == ORG_1KX2 && waddr_i[1:0] == B[2:1]) ||
                        (org_i == ORG_2KX1 && waddr_i[2:0] == B);
      assign wbits[b] = wdata_i[B & (3'h7 >> org_i)];
   end

   // Row update, only the masked bits change
   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem[wrow] <= (mem[wrow] & ~mask) | (wbits & mask);
      end
   end
endmodule : ram_array
`default_nettype wire

// file: rtl/fifo_ptrs.sv
// Read and write pointers and fill count of the queue mode
`default_nettype none
module fifo_ptrs
   import ram_block_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire logic              clr_i,
   input  wire logic [ADDR_W-1:0] depth_m1_i,
   input  wire logic              push_i,
   input  wire logic              pop_i,
   output logic      [ADDR_W-1:0] wr_ptr_o,
   output logic      [ADDR_W-1:0] rd_ptr_o,
   output logic      [CNT_W-1:0]  count_o,
   output logic                   full_o,
   output logic                   empty_o
);
   logic do_push;                     // Accepted push
   logic do_pop;                      // Accepted pop

   assign empty_o = (count_o == '0);
   assign full_o  = (count_o == CNT_W'({1'b0, depth_m1_i}) + 12'h001);
   assign do_push = push_i && !full_o;
   assign do_pop  = pop_i && !empty_o;

   // Pointers wrap at the organisation depth
   always_ff @(posedge clk_i) begin
      if (rst_i || (ce_i && clr_i)) begin
         wr_ptr_o <= '0;
         rd_ptr_o <= '0;
         count_o  <= '0;
      end else if (ce_i) begin
         if (do_push) begin
            wr_ptr_o <= (wr_ptr_o + 11'h001) & depth_m1_i;
         end
         if (do_pop) begin
            rd_ptr_o <= (rd_ptr_o + 11'h001) & depth_m1_i;
         end
         count_o <= count_o + CNT_W'(do_push) - CNT_W'(do_pop);
      end
   end
endmodule : fifo_ptrs
`default_nettype wire

// file: rtl/ram_block.sv
// Embedded RAM block top: modes, register stages, clock sourcing and APB setup
//
// Chosen here: the register addresses and the APB interface to the registers.
`default_nettype none
// How it works
// R1: Holds 2048 bits in every organisation
// R2: Single-port, ROM, dual-port or FIFO mode
// R3: Organisations 256x8, 512x4, 1024x2, 2048x1
// R4: ROM contents loaded by software, looked up
// R5: Write pulse made internally on clock tick
// R6: Input and output sides have own clocks
// R7: Data-in, data-out, address stages each bypassable
// R8: Write request from global or local logic
// R9: Clocks from global, dedicated pin or local
// R10: Side-by-side blocks share addresses for width
// R11: Bank compare cascades depth without extra delay
// R12: Built-in fill makes 4x4 multiplier table
// R13: Each global driven by pin or logic
// R14: Written word reads back, output stage delays
module ram_block
   import ram_block_pkg::*;
(
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESET_I,
   input  wire logic              CE_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [11:0]       PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic [GLB_N-1:0]  GLB_PIN_I,
   input  wire logic [GLB_N-1:0]  GLB_LOGIC_I,
   input  wire logic              DED_CLK_I,
   input  wire logic              LOCAL_CLK_I,
   input  wire logic              WE_LOCAL_I,
   input  wire logic [ADDR_W-1:0] ADDR_I,
   input  wire logic [ADDR_W-1:0] RD_ADDR_I,
   input  wire logic [BANK_W-1:0] BANK_I,
   input  wire logic [DATA_W-1:0] DATA_I,
   input  wire logic              RD_REQ_I,
   output logic      [DATA_W-1:0] DATA_O,
   output logic                   HIT_O,
   output logic                   FULL_O,
   output logic                   EMPTY_O
);
   // Register file
   ctrl_s             ctrl_reg;          // Mode, organisation and stage selects
   clksel_s           clksel_reg;        // Clock and strobe sources
   logic [ADDR_W-1:0] ldaddr_reg;        // Software load pointer
   logic              ldwr_reg;          // Software load write pending
   logic [DATA_W-1:0] lddata_reg;        // Software load data
   logic [ADDR_W-1:0] ldwaddr_reg;       // Address of the pending load write

   // Clock source edge detection
   logic              in_prev_reg;       // Input clock source last cycle
   logic              out_prev_reg;      // Output clock source last cycle

   // Input side stages
   logic [ADDR_W-1:0] addr_reg;          // Staged write and read address
   logic [ADDR_W-1:0] rdaddr_reg;        // Staged second-port read address
   logic [BANK_W-1:0] bank_reg;          // Staged bank number
   logic              we_reg;            // Staged write request
   logic [DATA_W-1:0] din_reg;           // Staged write data

   // Product table fill
   fill_e             fill_state;        // Fill machine state
   fill_e             fill_next;         // Its next value
   logic [7:0]        fill_cnt_reg;      // Table entry being written

   // APB answer and block output flops
   logic              pready_reg;
   logic [31:0]       prdata_reg;
   logic              pslverr_reg;
   logic [DATA_W-1:0] dout_reg;
   logic              hit_reg;
   logic              full_reg, empty_reg; // Registered queue flags

   // Decode wires
   logic [GLB_N-1:0]  glb;               // Resolved global signals
   logic              in_src_lvl;        // Selected input clock level
   logic              out_src_lvl;       // Selected output clock level
   logic              in_tick;           // Input clock rising edge
   logic              out_tick;          // Output clock rising edge
   logic              we_lvl;            // Selected write request level
   logic [ADDR_W-1:0] eff_addr;
   logic [ADDR_W-1:0] eff_rdaddr;
   logic [BANK_W-1:0] eff_bank;
   logic              eff_we;
   logic [DATA_W-1:0] eff_din;
   logic              hit;               // Bank compare result
   logic              user_wr;           // User write this cycle
   logic              fifo_push;
   logic              fifo_pop;
   logic [ADDR_W-1:0] wr_ptr;
   logic [ADDR_W-1:0] rd_ptr;
   logic [CNT_W-1:0]  fifo_cnt;
   logic              fifo_full;
   logic              fifo_empty;
   logic [ADDR_W-1:0] depth_m1;          // Words minus one for the organisation
   logic              mem_we;
   org_e              mem_org;
   logic [ADDR_W-1:0] mem_waddr;
   logic [DATA_W-1:0] mem_wdata;
   logic [ADDR_W-1:0] mem_raddr;
   logic [DATA_W-1:0] mem_rdata;
   logic              fill_busy;
   logic [7:0]        product;           // High nibble times low nibble
   logic              apb_setup;
   logic              apb_wr;
   logic              fill_start;
   logic              fifo_clr;
   logic [31:0]       rd_mux;
   logic              rd_err;
   status_s           status;

   // Each global comes from its pin or from internal logic
   // R13: global drive choice
   assign glb = (GLB_LOGIC_I & clksel_reg.glb_from_logic) |
                (GLB_PIN_I & ~clksel_reg.glb_from_logic);

   // Clock source selection for both sides
   // R9: clock source select
   assign in_src_lvl  = (clksel_reg.in_src == SRC_GLOBAL) ? glb[clksel_reg.in_glb] :
                        (clksel_reg.in_src == SRC_PIN)    ? DED_CLK_I : LOCAL_CLK_I;
   assign out_src_lvl = (clksel_reg.out_src == SRC_GLOBAL) ? glb[clksel_reg.out_glb] :
                        (clksel_reg.out_src == SRC_PIN)    ? DED_CLK_I : LOCAL_CLK_I;
   // R6: separate side clocks
   assign in_tick  = in_src_lvl && !in_prev_reg;
   assign out_tick = out_src_lvl && !out_prev_reg;

   // Write request from a global or from local routing
   // R8: write request source
   assign we_lvl = clksel_reg.we_from_glb ? glb[clksel_reg.we_glb] : WE_LOCAL_I;

   // Stage bypass: staged value or the live input
   // R7: stage bypass muxes
   assign eff_addr   = ctrl_reg.reg_addr ? addr_reg : ADDR_I;
   assign eff_rdaddr = ctrl_reg.reg_addr ? rdaddr_reg : RD_ADDR_I;
   assign eff_bank   = ctrl_reg.reg_addr ? bank_reg : BANK_I;
   assign eff_we     = ctrl_reg.reg_addr ? we_reg : we_lvl;
   assign eff_din    = ctrl_reg.reg_din ? din_reg : DATA_I;

   // Depth cascading: only the addressed bank answers
   // R11: bank compare
   assign hit = !ctrl_reg.casc_en || (eff_bank == ctrl_reg.bank_id);

   // Internal write pulse, one cycle per input tick
   // R5: self-timed write pulse
   assign user_wr   = in_tick && eff_we && hit && (ctrl_reg.mode != MODE_ROM);
   assign fifo_push = user_wr && (ctrl_reg.mode == MODE_FIFO);
   assign fifo_pop  = out_tick && RD_REQ_I && hit && (ctrl_reg.mode == MODE_FIFO);

   // Depth follows the organisation
   // R3: depth per organisation
   assign depth_m1 = ADDR_W'((DEPTH_BASE << ctrl_reg.org) - 12'h001);

   // Multiplier table entry
   // R12: product entry
   assign product   = 8'(fill_cnt_reg[7:4]) * 8'(fill_cnt_reg[3:0]);
   assign fill_busy = (fill_state == FILL_RUN);

   // Write port arbitration: fill, then software load, then user
   // R4: software load path
   assign mem_we    = fill_busy || ldwr_reg || (user_wr && !(fifo_push && fifo_full));
   assign mem_org   = fill_busy ? ORG_256X8 : ctrl_reg.org;
   assign mem_waddr = fill_busy ? ADDR_W'(fill_cnt_reg) :
                      ldwr_reg  ? ldwaddr_reg :
                      (ctrl_reg.mode == MODE_FIFO) ? wr_ptr : eff_addr & depth_m1;
   assign mem_wdata = fill_busy ? product : ldwr_reg ? lddata_reg : eff_din;

   // Read address per mode
   // R2: mode address select
   assign mem_raddr = (ctrl_reg.mode == MODE_FIFO)  ? rd_ptr :
                      (ctrl_reg.mode == MODE_DPRAM) ? eff_rdaddr & depth_m1 :
                      eff_addr & depth_m1;

   // R1: full storage array
   ram_array u_array (
      .clk_i   (SYS_CLK_I),
      .ce_i    (CE_I),
      .we_i    (mem_we),
      .org_i   (mem_org),
      .waddr_i (mem_waddr),
      .wdata_i (mem_wdata),
      .raddr_i (mem_raddr),
      .rdata_o (mem_rdata)
   );

   // Queue pointers, cleared when the mode or organisation is written
   assign fifo_clr = apb_wr && (PADDR_I == OFS_CTRL);
   fifo_ptrs u_fifo (
      .clk_i      (SYS_CLK_I),
      .rst_i      (RESET_I),
      .ce_i       (CE_I),
      .clr_i      (fifo_clr),
      .depth_m1_i (depth_m1),
      .push_i     (fifo_push),
      .pop_i      (fifo_pop),
      .wr_ptr_o   (wr_ptr),
      .rd_ptr_o   (rd_ptr),
      .count_o    (fifo_cnt),
      .full_o     (fifo_full),
      .empty_o    (fifo_empty)
   );

   // APB decode
   assign apb_setup  = PSEL_I && !PENABLE_I;
   assign apb_wr     = PSEL_I && PENABLE_I && pready_reg && PWRITE_I;
   assign fill_start = apb_wr && (PADDR_I == OFS_CTRL) && PWDATA_I[FILL_BIT];
   assign status     = '{hit: hit, fill_busy: fill_busy, full: fifo_full,
                         empty: fifo_empty, count: fifo_cnt};

   // Read data select, unmapped offsets answer with an error
   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_err = 1'b0;
      if (PADDR_I == OFS_CTRL) begin
         rd_mux = 32'(ctrl_reg);
      end else if (PADDR_I == OFS_CLKSEL) begin
         rd_mux = 32'(clksel_reg);
      end else if (PADDR_I == OFS_LDADDR) begin
         rd_mux = 32'(ldaddr_reg);
      end else if (PADDR_I == OFS_LDDATA) begin
         rd_mux = 32'(lddata_reg);
      end else if (PADDR_I == OFS_STATUS) begin
         rd_mux = 32'(status);
      end else begin
         rd_err = 1'b1;
      end
   end

   // Fill machine next state
   always_comb begin
      fill_next = fill_state;
      case (fill_state)
         FILL_IDLE: begin
            if (fill_start) begin
               fill_next = FILL_RUN;
            end
         end
         FILL_RUN: begin
            if (fill_cnt_reg == FILL_LAST) begin
               fill_next = FILL_IDLE;
            end
         end
         default: begin
            fill_next = FILL_IDLE;
         end
      endcase
   end

   // APB answer: ready in the first access cycle
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         pready_reg  <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (CE_I) begin
         pready_reg <= apb_setup;
         if (apb_setup) begin
            prdata_reg  <= PWRITE_I ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= rd_err;
         end
      end
   end

   // Configuration registers
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         ctrl_reg   <= CTRL_RST;
         clksel_reg <= CLKSEL_RST;
      end else if (CE_I && apb_wr) begin
         if (PADDR_I == OFS_CTRL) begin
            ctrl_reg <= ctrl_s'(PWDATA_I[$bits(ctrl_s)-1:0]);
         end else if (PADDR_I == OFS_CLKSEL) begin
            clksel_reg <= clksel_s'(PWDATA_I[$bits(clksel_s)-1:0]);
         end
      end
   end

   // Software load port: each data write stores one word, unless the fill is running, and steps the pointer
   // R4: pattern load
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         ldaddr_reg  <= '0;
         ldwaddr_reg <= '0;
         lddata_reg  <= '0;
         ldwr_reg    <= 1'b0;
      end else if (CE_I) begin
         ldwr_reg <= apb_wr && (PADDR_I == OFS_LDDATA);
         if (apb_wr && PADDR_I == OFS_LDADDR) begin
            ldaddr_reg <= PWDATA_I[ADDR_W-1:0];
         end else if (apb_wr && PADDR_I == OFS_LDDATA) begin
            lddata_reg  <= PWDATA_I[DATA_W-1:0];
            ldwaddr_reg <= ldaddr_reg & depth_m1;
            ldaddr_reg  <= (ldaddr_reg + 11'h001) & depth_m1;
         end
      end
   end

   // Fill machine and entry counter
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         fill_state   <= FILL_IDLE;
         fill_cnt_reg <= 8'h00;
      end else if (CE_I) begin
         fill_state <= fill_next;
         // R12: walk all entries
         fill_cnt_reg <= fill_busy ? fill_cnt_reg + 8'h01 : 8'h00;
      end
   end

   // Source history for edge detection
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         in_prev_reg  <= 1'b0;
         out_prev_reg <= 1'b0;
      end else if (CE_I) begin
         in_prev_reg  <= in_src_lvl;
         out_prev_reg <= out_src_lvl;
      end
   end

   // Input side stages load on the input clock tick
   // R7: input stages
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         addr_reg   <= '0;
         rdaddr_reg <= '0;
         bank_reg   <= '0;
         we_reg     <= 1'b0;
         din_reg    <= '0;
      end else if (CE_I && in_tick) begin
         addr_reg   <= ADDR_I;
         rdaddr_reg <= RD_ADDR_I;
         bank_reg   <= BANK_I;
         we_reg     <= we_lvl;
         din_reg    <= DATA_I;
      end
   end

   // Output: staged on the output tick, or following the array each cycle
   // R14: read back timing
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         dout_reg <= '0;
         hit_reg  <= 1'b0;
         full_reg  <= 1'b0;
         empty_reg <= 1'b1;
      end else if (CE_I) begin
         hit_reg <= hit;
         full_reg  <= fifo_full;
         empty_reg <= fifo_empty;
         // R6: output side clock
         if (!ctrl_reg.reg_dout || out_tick) begin
            dout_reg <= hit ? mem_rdata : '0;
         end
      end
   end

   // R10: shared address width expansion
   assign DATA_O    = dout_reg;
   assign HIT_O     = hit_reg;
   assign FULL_O    = full_reg;
   assign EMPTY_O   = empty_reg;
   assign PRDATA_O  = prdata_reg;
   assign PREADY_O  = pready_reg;
   assign PSLVERR_O = pslverr_reg;
endmodule : ram_block
`default_nettype wire

// file: tb/ram_block_chk.sv
// Port assertions of the embedded RAM block
`default_nettype none
module ram_block_chk
   import ram_block_pkg::*;
(
   input wire logic              SYS_CLK_I,
   input wire logic              RESET_I,
   input wire logic              CE_I,
   input wire logic              PSEL_I,
   input wire logic              PENABLE_I,
   input wire logic [11:0]       PADDR_I,
   input wire logic [31:0]       PRDATA_O,
   input wire logic              PREADY_O,
   input wire logic              PSLVERR_O,
   input wire logic [DATA_W-1:0] DATA_O,
   input wire logic              HIT_O,
   input wire logic              FULL_O,
   input wire logic              EMPTY_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (RESET_I);
   // Bus setup and answered access
   sequence setup_s; PSEL_I && !PENABLE_I && CE_I; endsequence
   sequence acc_s; PSEL_I && PENABLE_I && PREADY_O; endsequence
   ready_next_a: assert property (setup_s |=> acc_s) else $error("no ready");
   ready_drop_a: assert property (acc_s and CE_I |=> !PREADY_O) else $error("ready held");
   bad_ofs_a: assert property (acc_s and PADDR_I > 12'h010 |-> PSLVERR_O && PRDATA_O == '0)
      else $error("unmapped accepted");
   good_ofs_a: assert property (acc_s and PADDR_I <= 12'h010 && PADDR_I[1:0] == 2'h0
      |-> !PSLVERR_O) else $error("mapped refused");
   flags_excl_a: assert property (!(FULL_O && EMPTY_O)) else $error("full and empty");
   reset_state_a: assert property ($fell(RESET_I) && CE_I |-> EMPTY_O ##[1:2] HIT_O)
      else $error("bad state after reset");
   cold_data_a: assert property (!HIT_O |-> DATA_O == '0) else $error("data not hit");
   freeze_a: assert property (!CE_I |=> $stable(DATA_O) && $stable(PREADY_O))
      else $error("moved while frozen");
endmodule : ram_block_chk
bind ram_block ram_block_chk i_ram_block_chk(.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
   .CE_I(CE_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .DATA_O(DATA_O),
   .HIT_O(HIT_O), .FULL_O(FULL_O), .EMPTY_O(EMPTY_O));
`default_nettype wire

// file: tb/ram_user_logic.sv
// User logic model feeding the block from local routing
`default_nettype none
module ram_user_logic
   import ram_block_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              go_i,    // One local clock tick
   input  wire logic              wr_i,    // Tick carries a write
   input  wire logic              pop_i,   // Tick carries a pop
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] data_i,
   output logic                   lclk_o,
   output logic                   we_o,
   output logic                   rd_o,
   output logic      [ADDR_W-1:0] addr_o,
   output logic      [DATA_W-1:0] data_o
);
   initial {lclk_o, we_o, rd_o, addr_o, data_o} = '0;
   // local write request; clock idles low, idle data toggles
   always @(posedge clk_i) begin
      lclk_o <= go_i;
      we_o   <= go_i && wr_i;
      rd_o   <= go_i && pop_i;
      addr_o <= go_i ? addr_i : addr_o;
      data_o <= (go_i && wr_i) ? data_i : ~data_o;
   end
endmodule : ram_user_logic
`default_nettype wire

// file: tb/ram_block_bench.sv
// Self-checking bench of the embedded RAM block
`default_nettype none
module ram_block_bench
   import ram_block_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0]       paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic              pready, er, go = 1'b0, wr = 1'b0, pop = 1'b0, lclk, we, rq;
   logic              hit, full, empty;
   logic [ADDR_W-1:0] ua = '0, ua_o;
   logic [DATA_W-1:0] ud = '0, ud_o, dout;
   int                n_errors = 0, checks_done = 0;
   always #12.5 clk = ~clk;
   ram_user_logic i_ram_user_logic(.clk_i(clk), .go_i(go), .wr_i(wr), .pop_i(pop),
      .addr_i(ua), .data_i(ud), .lclk_o(lclk), .we_o(we), .rd_o(rq), .addr_o(ua_o),
      .data_o(ud_o));
   ram_block i_ram_block(.SYS_CLK_I(clk), .RESET_I(rst), .CE_I(ce), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(er), .GLB_PIN_I(4'h0), .GLB_LOGIC_I(4'h0),
      .DED_CLK_I(1'b0), .LOCAL_CLK_I(lclk), .WE_LOCAL_I(we), .ADDR_I(ua_o),
      .RD_ADDR_I(11'h000), .BANK_I(3'h0), .DATA_I(ud_o), .RD_REQ_I(rq), .DATA_O(dout),
      .HIT_O(hit), .FULL_O(full), .EMPTY_O(empty));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One bus transfer, held until ready is sampled
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel   <= 1'b1;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen    <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd     = prdata;
      psel   <= 1'b0;
      pen    <= 1'b0;
      @(posedge clk);
   endtask : apb
   // One local tick, then time for the read word to land
   task automatic tick(input logic w, input logic [10:0] a, input logic [7:0] d);
      go <= 1'b1;
      wr <= w;
      ua <= a;
      ud <= d;
      @(posedge clk);
      go <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : tick
   task automatic peek(input logic [10:0] a, input logic [7:0] e);
      tick(1'b0, a, 8'h00);
      chk({24'h0, dout}, {24'h0, e});
   endtask : peek
   task automatic t_regs;
      apb(1'b0, OFS_CLKSEL, 32'h0);
      chk(rd, 32'h0000_000a);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0000_9000);
      apb(1'b0, 12'h014, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
   endtask : t_regs
   task automatic t_orgs;
      tick(1'b1, 11'h005, 8'ha5);
      tick(1'b1, 11'h0ff, 8'h3c);
      ce <= 1'b0;
      repeat (2) @(posedge clk);
      ce <= 1'b1;
      peek(11'h005, 8'ha5);
      apb(1'b1, OFS_CTRL, 32'h0000_000c);
      tick(1'b1, 11'h7ff, 8'hff);
      tick(1'b1, 11'h7fe, 8'h00);
      peek(11'h7ff, 8'h01);
      apb(1'b1, OFS_CTRL, 32'h0);
      peek(11'h0ff, 8'hbc);
   endtask : t_orgs
   task automatic t_rom;
      apb(1'b1, OFS_CTRL, 32'h0000_0001);
      apb(1'b1, OFS_LDADDR, 32'h0000_0003);
      apb(1'b1, OFS_LDDATA, 32'h0000_005a);
      tick(1'b1, 11'h003, 8'h00);
      chk({24'h0, dout}, 32'h0000_005a);
      apb(1'b1, OFS_CTRL, 32'h0001_0001);
      repeat (260) @(posedge clk);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk({31'h0, rd[14]}, 32'h0);
      peek(11'h0ff, 8'he1);
      peek(11'h034, 8'h0c);
   endtask : t_rom
   task automatic t_fifo;
      apb(1'b1, OFS_CTRL, 32'h0000_0003);
      tick(1'b1, 11'h000, 8'h77);
      chk({hit, full, empty, dout}, {3'b100, 8'h77});
      pop <= 1'b1;
      tick(1'b0, 11'h000, 8'h00);
      pop <= 1'b0;
      chk({31'h0, empty}, 32'h1);
   endtask : t_fifo
   task automatic results;
      $display("errors=%0d checks=%0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_orgs();
      t_rom();
      t_fifo();
      results();
   end
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      results();
   end
endmodule : ram_block_bench
`default_nettype wire
